// ---- rtl/spfd_pkg.sv ----
// Purpose: Shared constants, types and reset values of the supervisor block
// Assumes: 20 MHz system clock, APB register access, 32-bit data
// Notes:   Byte address of a register is four times its index
package spfd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int TREC_LONG_MS = 96;
  localparam int TREC_DEF_MS = 40;
  localparam int TREC_SHORT_US = 50;
  localparam int CHECK_HOURS = 24;
  localparam int TREC_LONG_CYC = (TREC_LONG_MS * CLK_HZ + 999) / 1000;
  localparam int TREC_DEF_CYC = (TREC_DEF_MS * CLK_HZ + 999) / 1000;
  localparam int TREC_SHORT_CYC =
    (TREC_SHORT_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam longint CHECK_CYC = longint'(CHECK_HOURS) * 3600 * CLK_HZ;
  localparam int TMR_W = 24;
  localparam int DAY_W = 42;

  // ----------------------------------------------------------------
  // Register map (indexes) and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_HALT = 6'h01;
  localparam logic [IDX_W-1:0] IDX_CENT = 6'h03;
  localparam logic [IDX_W-1:0] IDX_TREC = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h08;
  localparam logic [IDX_W-1:0] IDX_WDOG = 6'h09;
  localparam logic [IDX_W-1:0] IDX_ALRM = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_HTF = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_FLAG = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_ISTAT = 6'h10;
  localparam logic [IDX_W-1:0] IDX_ICLR = 6'h11;
  localparam logic [IDX_W-1:0] IDX_IEN = 6'h12;
  localparam int B_HALT = 7;
  localparam int B_CENT_EN = 7;
  localparam int B_CENT_FLAG = 6;
  localparam int B_TREC = 7;
  localparam int B_OUT = 7;
  localparam int B_FT = 6;
  localparam int B_PIN_RB = 0;
  localparam int B_WDS = 7;
  localparam int B_AFE = 7;
  localparam int B_SQW = 6;
  localparam int B_ABE = 5;
  localparam int B_HT = 6;
  localparam int B_WEAK = 4;
  localparam int WD_W = 8;

  // Interrupt events
  localparam int EV_W = 3;
  localparam int EV_WEAK = 0;
  localparam int EV_PFAIL = 1;
  localparam int EV_CENT = 2;

  // Synchronised pins
  localparam int NIN = 4;
  localparam int IN_SENSE = 0;
  localparam int IN_VGOOD = 1;
  localparam int IN_CELL = 2;
  localparam int IN_PIN = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_BACKUP = 2'b00,
    PWR_RECOVER = 2'b01,
    PWR_NORMAL = 2'b10
  } spfd_pwr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } spfd_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } spfd_apb_rsp_t;

  typedef struct packed {
    logic halt;
    logic centEn;
    logic centFlag;
    logic trecSel;
    logic outBit;
    logic freqTest;
    logic afe;
    logic abe;
    logic sqw;
    logic ht;
    logic cellWeak;
    logic [WD_W-1:0] wd;
  } spfd_ctl_t;

  localparam spfd_ctl_t CTL_RST = '{halt: 1'b1, centEn: 1'b0,
    centFlag: 1'b0, trecSel: 1'b0, outBit: 1'b1, freqTest: 1'b0,
    afe: 1'b0, abe: 1'b0, sqw: 1'b0, ht: 1'b1, cellWeak: 1'b0,
    wd: 8'h00};

  typedef struct packed {
    spfd_pwr_t pwr;
    logic [TMR_W-1:0] tmr;
    logic [DAY_W-1:0] day;
    logic [NIN-1:0][2:0] sync;
    logic [NIN-1:0] filt;
    spfd_ctl_t ctl;
    logic [EV_W-1:0] istat;
    logic [EV_W-1:0] ien;
    spfd_apb_rsp_t rsp;
    logic pfoN;
    logic pinLow;
    logic wp;
    logic testStrobe;
    logic irq;
  } spfd_state_t;

endpackage

// ---- rtl/spfd_supervisor.sv ----
// Purpose: Supply-fail gating, deselect extension, century flag, output
//          driver pin, battery check and power-up defaults
// Assumes: Analog comparators deliver digital levels on asynchronous pins
// Notes:   Reset stands for the first application of power
`timescale 1ns/1ps

module spfd_supervisor #(
  parameter int TrecLongCyc = spfd_pkg::TREC_LONG_CYC,
  parameter int TrecDefCyc = spfd_pkg::TREC_DEF_CYC,
  parameter int TrecShortCyc = spfd_pkg::TREC_SHORT_CYC,
  parameter longint CheckCyc = spfd_pkg::CHECK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire spfd_pkg::spfd_apb_req_t apbReq,
  output spfd_pkg::spfd_apb_rsp_t apbRsp,
  // Analog comparator levels (asynchronous)
  input wire logic supplySenseLow,
  input wire logic supplyGood,
  input wire logic cellLow,
  // Sources sharing the output pin, and century rollover (same clock)
  input wire logic wdFire,
  input wire logic alarmAct,
  input wire logic ftWave,
  input wire logic centuryRollover,
  // Supply fail output
  output logic supply_fail_output_n,
  // Open-drain multi-function pin
  input wire logic mfpIn,
  output logic mfpOut,
  output logic mfpOe,
  // Status towards the rest of the chip
  output spfd_pkg::spfd_ctl_t ctlOut,
  output logic writeProtect,
  output logic cellTestStrobe,
  output logic irq
);
  import spfd_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (TrecLongCyc < 1 || TrecDefCyc < 1 || TrecShortCyc < 1 ||
        TrecLongCyc >= (1 << TMR_W) || TrecDefCyc >= (1 << TMR_W) ||
        TrecShortCyc >= (1 << TMR_W)) begin : gBadTrec
      $error("deselect count out of timer range");
    end
    if (CheckCyc < 2 || CheckCyc >= (longint'(1) << DAY_W)) begin : gBadDay
      $error("check period out of counter range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam spfd_state_t ST_RST = '{
    pwr: PWR_BACKUP,
    tmr: '0,
    day: '0,
    sync: '0,
    filt: '0,
    ctl: CTL_RST,
    istat: '0,
    ien: '0,
    rsp: '{prdata: '0, pready: 1'b0, pslverr: 1'b0},
    pfoN: 1'b0,
    pinLow: 1'b0,
    wp: 1'b1,
    testStrobe: 1'b0,
    irq: 1'b0
  };

  spfd_state_t s;
  spfd_state_t n;
  logic [NIN-1:0] rawPins;
  logic [IDX_W-1:0] idx;
  logic setupCyc;
  logic access;
  logic wrEn;
  logic mapped;
  logic [DATA_W-1:0] rdData;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clrMask;
  logic testNow;
  logic [TMR_W-1:0] trecLoad;

  assign rawPins = {mfpIn, cellLow, supplyGood, supplySenseLow};
  assign idx = apbReq.paddr[ADDR_W-1:2];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    ev = '0;
    clrMask = '0;
    testNow = 1'b0;
    n.testStrobe = 1'b0;

    // Three stages; a change counts once stages two and three agree
    for (int i = 0; i < NIN; i++) begin
      n.sync[i] = {s.sync[i][1:0], rawPins[i]};
      if (s.sync[i][1] == s.sync[i][2]) begin
        n.filt[i] = s.sync[i][2];
      end
    end

    // Length follows the bits as they stand when power returns
    if (s.ctl.trecSel) begin
      trecLoad = TMR_W'(TrecShortCyc - 1);
    end else if (s.ctl.halt) begin
      trecLoad = TMR_W'(TrecDefCyc - 1);
    end else begin
      trecLoad = TMR_W'(TrecLongCyc - 1);
    end

    // ---------------- APB decode and read mux ----------------
    setupCyc = apbReq.psel & apbReq.penable & ~s.rsp.pready;
    access = apbReq.psel & apbReq.penable & s.rsp.pready;
    // Writes only land with the supply settled
    // A write refused at the first access edge stays refused
    wrEn = access & apbReq.pwrite & ~s.rsp.pslverr &
      (s.pwr == PWR_NORMAL);
    mapped = 1'b1;
    rdData = '0;
    case (idx)
      IDX_HALT: rdData[B_HALT] = s.ctl.halt;
      IDX_CENT: begin
        rdData[B_CENT_EN] = s.ctl.centEn;
        rdData[B_CENT_FLAG] = s.ctl.centFlag;
      end
      IDX_TREC: rdData[B_TREC] = s.ctl.trecSel;
      IDX_CTRL: begin
        rdData[B_OUT] = s.ctl.outBit;
        rdData[B_FT] = s.ctl.freqTest;
        rdData[B_PIN_RB] = s.filt[IN_PIN];
      end
      IDX_WDOG: rdData[WD_W-1:0] = s.ctl.wd;
      IDX_ALRM: begin
        rdData[B_AFE] = s.ctl.afe;
        rdData[B_SQW] = s.ctl.sqw;
        rdData[B_ABE] = s.ctl.abe;
      end
      IDX_HTF: rdData[B_HT] = s.ctl.ht;
      IDX_FLAG: rdData[B_WEAK] = s.ctl.cellWeak;
      IDX_ISTAT: rdData[EV_W-1:0] = s.istat;
      IDX_ICLR: rdData = '0;
      IDX_IEN: rdData[EV_W-1:0] = s.ien;
      default: mapped = 1'b0;
    endcase

    // One wait state: answer on the second access-phase edge
    n.rsp.pready = setupCyc;
    if (setupCyc) begin
      n.rsp.prdata = apbReq.pwrite ? '0 : rdData;
      n.rsp.pslverr = ~mapped |
        (apbReq.pwrite & (s.pwr != PWR_NORMAL));
    end

    if (wrEn) begin
      case (idx)
        IDX_HALT: n.ctl.halt = apbReq.pwdata[B_HALT];
        IDX_CENT: begin
          n.ctl.centEn = apbReq.pwdata[B_CENT_EN];
          n.ctl.centFlag = apbReq.pwdata[B_CENT_FLAG];
        end
        IDX_TREC: n.ctl.trecSel = apbReq.pwdata[B_TREC];
        IDX_CTRL: begin
          n.ctl.outBit = apbReq.pwdata[B_OUT];
          n.ctl.freqTest = apbReq.pwdata[B_FT];
        end
        IDX_WDOG: n.ctl.wd = apbReq.pwdata[WD_W-1:0];
        IDX_ALRM: begin
          n.ctl.afe = apbReq.pwdata[B_AFE];
          n.ctl.sqw = apbReq.pwdata[B_SQW];
          n.ctl.abe = apbReq.pwdata[B_ABE];
        end
        IDX_HTF: n.ctl.ht = apbReq.pwdata[B_HT];
        IDX_ICLR: clrMask = apbReq.pwdata[EV_W-1:0];
        IDX_IEN: n.ien = apbReq.pwdata[EV_W-1:0];
        default: ;
      endcase
    end

    // ---------------- Power sequencing ----------------
    unique case (s.pwr)
      PWR_BACKUP: begin
        n.pfoN = 1'b0;
        n.wp = 1'b1;
        n.day = '0;
        if (s.filt[IN_VGOOD]) begin
          n.pwr = PWR_RECOVER;
          n.tmr = trecLoad;
          // Halt and level bits are left as retained
          n.ctl.freqTest = 1'b0;
          n.ctl.afe = 1'b0;
          n.ctl.abe = 1'b0;
          n.ctl.sqw = 1'b0;
          n.ctl.wd = '0;
          n.ctl.ht = 1'b1;
          testNow = 1'b1;
        end
      end
      PWR_RECOVER: begin
        n.pfoN = 1'b1;
        n.wp = 1'b1;
        if (!s.filt[IN_VGOOD]) begin
          n.pwr = PWR_BACKUP;
        end else if (s.tmr == '0) begin
          n.pwr = PWR_NORMAL;
        end else begin
          n.tmr = s.tmr - TMR_W'(1);
        end
      end
      PWR_NORMAL: begin
        n.pfoN = ~s.filt[IN_SENSE];
        n.wp = 1'b0;
        if (!s.filt[IN_VGOOD]) begin
          n.pwr = PWR_BACKUP;
        end else if (s.day == DAY_W'(CheckCyc - 1)) begin
          n.day = '0;
          testNow = 1'b1;
        end else begin
          n.day = s.day + DAY_W'(1);
        end
      end
    endcase

    // A test only runs with supply present, and its verdict replaces
    // the old one, so a fresh cell clears the flag at the next test
    if (testNow && s.filt[IN_VGOOD]) begin
      n.testStrobe = 1'b1;
      n.ctl.cellWeak = s.filt[IN_CELL];
      ev[EV_WEAK] = s.filt[IN_CELL];
    end

    // Rollover is applied after a software write of the same cycle
    if (centuryRollover && s.ctl.centEn) begin
      n.ctl.centFlag = ~n.ctl.centFlag;
      ev[EV_CENT] = 1'b1;
    end

    ev[EV_PFAIL] = s.pfoN & ~n.pfoN;

    // ---------------- Multi-function pin ----------------
    if (s.ctl.wd != '0 && !s.ctl.wd[B_WDS]) begin
      n.pinLow = wdFire;
    end else if (s.ctl.freqTest) begin
      n.pinLow = ~ftWave;
    end else if (s.ctl.afe && (s.pwr == PWR_NORMAL || s.ctl.abe)) begin
      n.pinLow = alarmAct;
    end else begin
      n.pinLow = ~s.ctl.outBit;
    end

    // Set beats clear so no event is lost
    n.istat = (s.istat & ~clrMask) | ev;
    n.irq = |(n.istat & n.ien);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign apbRsp = s.rsp;
  assign supply_fail_output_n = s.pfoN;
  assign mfpOe = s.pinLow;
  assign mfpOut = s.ctl.wd[B_WDS] & 1'b0;
  assign ctlOut = s.ctl;
  assign writeProtect = s.wp;
  assign cellTestStrobe = s.testStrobe;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fail_tracks: assert property (@(posedge sys_clk) disable iff (rst)
    s.pwr == PWR_NORMAL |=> s.pfoN == !$past(s.filt[IN_SENSE]))
    else $error("fail output does not follow sense in normal power");

  chk_fail_backup: assert property (@(posedge sys_clk) disable iff (rst)
    s.pwr == PWR_BACKUP |=> !s.pfoN)
    else $error("fail output not low in backup");

  chk_fail_forced: assert property (@(posedge sys_clk) disable iff (rst)
    s.pwr == PWR_RECOVER |=> s.pfoN && s.wp)
    else $error("fail output not forced high during deselect");

  chk_century_flip: assert property (@(posedge sys_clk) disable iff (rst)
    centuryRollover && s.ctl.centEn && !(wrEn && idx == IDX_CENT)
    |=> s.ctl.centFlag != $past(s.ctl.centFlag) && s.istat[EV_CENT])
    else $error("century flag did not invert");

  chk_century_hold: assert property (@(posedge sys_clk) disable iff (rst)
    centuryRollover && !s.ctl.centEn && !(wrEn && idx == IDX_CENT)
    |=> $stable(s.ctl.centFlag))
    else $error("century flag changed while disabled");

  chk_pin_level: assert property (@(posedge sys_clk) disable iff (rst)
    !s.ctl.freqTest && !s.ctl.afe && s.ctl.wd == '0
    |=> mfpOe == !$past(s.ctl.outBit))
    else $error("pin does not follow level bit");

  chk_wd_prevails: assert property (@(posedge sys_clk) disable iff (rst)
    s.ctl.wd != '0 && !s.ctl.wd[B_WDS] && s.ctl.freqTest && wdFire
    |=> mfpOe)
    else $error("frequency test took the pin from the watchdog");

  chk_weak_set: assert property (@(posedge sys_clk) disable iff (rst)
    s.pwr == PWR_NORMAL && s.filt[IN_VGOOD] && s.filt[IN_CELL] &&
    s.day == DAY_W'(CheckCyc - 1)
    |=> s.ctl.cellWeak && s.testStrobe)
    else $error("failed cell test did not set weak flag");

  chk_no_backup_test: assert property (@(posedge sys_clk)
    disable iff (rst)
    s.pwr == PWR_BACKUP && !s.filt[IN_VGOOD]
    |=> !s.testStrobe && $stable(s.ctl.cellWeak))
    else $error("cell test during backup");

  chk_write_refused: assert property (@(posedge sys_clk)
    disable iff (rst)
    access && apbReq.pwrite && idx == IDX_CENT && s.pwr != PWR_NORMAL &&
    !centuryRollover
    |=> $stable(s.ctl.centEn) && $stable(s.ctl.centFlag))
    else $error("write accepted during deselect");

  chk_short_trec: assert property (@(posedge sys_clk) disable iff (rst)
    s.pwr == PWR_BACKUP && s.filt[IN_VGOOD] && s.ctl.trecSel
    |=> s.pwr == PWR_RECOVER && s.tmr == TMR_W'(TrecShortCyc - 1))
    else $error("short deselect length not loaded");

  chk_powerup_clear: assert property (@(posedge sys_clk)
    disable iff (rst)
    s.pwr == PWR_BACKUP && s.filt[IN_VGOOD]
    |=> s.ctl.wd == '0 && !s.ctl.freqTest && !s.ctl.afe && s.ctl.ht &&
        s.ctl.halt == $past(s.ctl.halt) && s.testStrobe)
    else $error("power-up defaults not applied");

  chk_century_read: assert property (@(posedge sys_clk) disable iff (rst)
    setupCyc && !apbReq.pwrite && idx == IDX_CENT
    |=> s.rsp.prdata[B_CENT_EN] == $past(s.ctl.centEn) &&
        s.rsp.prdata[B_CENT_FLAG] == $past(s.ctl.centFlag))
    else $error("century bits not read back");

  chk_weak_hold: assert property (@(posedge sys_clk) disable iff (rst)
    s.ctl.cellWeak && !(testNow && s.filt[IN_VGOOD])
    |=> s.ctl.cellWeak)
    else $error("weak flag dropped without a passing test");

endmodule

// ---- testbench/spfd_host_supply_model.sv ----
// Purpose: Host supply, backup cell and pin pull-up around the supervisor
// Assumes: Levels change just after a rising clock edge
// Notes:   The pin is open drain with a pull-up, so released reads high
`timescale 1ns/1ps

module spfd_host_supply_model (
  // Clock
  input wire logic sys_clk,
  // Requests from the bench
  input wire logic mainsOn,
  input wire logic senseLowReq,
  input wire logic cellLowReq,
  // Pin drive from the supervisor
  input wire logic mfpOe,
  input wire logic mfpOut,
  // Levels towards the supervisor
  output logic supplyGood,
  output logic supplySenseLow,
  output logic cellLow,
  output logic mfpIn
);
  initial begin
    supplyGood = 1'b0;
    supplySenseLow = 1'b0;
    cellLow = 1'b0;
  end

  always @(posedge sys_clk) begin
    supplyGood <= mainsOn;
    supplySenseLow <= senseLowReq;
    cellLow <= cellLowReq;
  end

  // Pull-up wins unless the supervisor sinks the pin
  assign mfpIn = (mfpOe === 1'b1 && mfpOut === 1'b0) ? 1'b0 : 1'b1;
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench of the supervisor block
// Assumes: Shortened deselect and daily counts, APB host in the bench
// Notes:   Reset stands for first power; supply cycles use the model
`timescale 1ns/1ps

module testbench;
  import spfd_pkg::*;
  localparam int LongC = 40;
  localparam int DefC = 30;
  localparam int ShortC = 10;
  localparam longint DayC = 200;
  localparam int Limit = 20000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  spfd_apb_req_t req = '0;
  spfd_apb_rsp_t rsp;
  logic mains = 1'b0;
  logic senseReq = 1'b0;
  logic cellReq = 1'b0;
  logic wdFire = 1'b0;
  logic ftWave = 1'b1;
  logic cent = 1'b0;
  logic alarm = 1'b0;
  logic good, senseLow, cellLow, mfpIn, mfpOut, mfpOe;
  logic pfoN, wp, stb, irq;
  spfd_ctl_t ctl;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int dselCnt = 0;
  int stbCnt = 0;
  int lastStb = 0;
  int gap = 0;

  always #25 sys_clk = ~sys_clk;

  spfd_supervisor #(.TrecLongCyc(LongC), .TrecDefCyc(DefC),
    .TrecShortCyc(ShortC), .CheckCyc(DayC)) spfd_supervisor_inst (
    .sys_clk(sys_clk), .rst(rst), .apbReq(req), .apbRsp(rsp),
    .supplySenseLow(senseLow), .supplyGood(good), .cellLow(cellLow),
    .wdFire(wdFire), .alarmAct(alarm), .ftWave(ftWave),
    .centuryRollover(cent), .supply_fail_output_n(pfoN), .mfpIn(mfpIn),
    .mfpOut(mfpOut), .mfpOe(mfpOe), .ctlOut(ctl), .writeProtect(wp),
    .cellTestStrobe(stb), .irq(irq));

  spfd_host_supply_model spfd_host_supply_model_inst (
    .sys_clk(sys_clk), .mainsOn(mains), .senseLowReq(senseReq),
    .cellLowReq(cellReq), .mfpOe(mfpOe), .mfpOut(mfpOut),
    .supplyGood(good), .supplySenseLow(senseLow), .cellLow(cellLow),
    .mfpIn(mfpIn));

  // --------------------------------------------------------------
  // Bookkeeping
  // --------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (pfoN === 1'b1 && wp === 1'b1) begin
      dselCnt <= dselCnt + 1;
    end
    if (stb === 1'b1) begin
      stbCnt <= stbCnt + 1;
      gap <= cycles - lastStb;
      lastStb <= cycles;
    end
    if (cycles == Limit) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    // One wait state: pready is seen at the second access edge
    chk("access edges", 2, n);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic ee);
    apb(1'b1, a, d);
    chk("pslverr", ee, rerr);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  // Selector: 0 pin sink, 1 fail output, 2 interrupt
  task automatic waitsig(input int s, input logic v, input string nm);
    logic g;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      g = (s == 0) ? mfpOe : (s == 1) ? pfoN : irq;
      if (g === v) break;
    end
    chk(nm, v, g);
  endtask

  task automatic pulse_cent();
    @(posedge sys_clk);
    cent <= 1'b1;
    @(posedge sys_clk);
    cent <= 1'b0;
  endtask

  task automatic wait_tests(input int k);
    int s0;
    s0 = stbCnt;
    for (int i = 0; i < 600 && stbCnt - s0 < k; i++) @(posedge sys_clk);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    spfd_ctl_t e;
    e = '0;
    e.halt = 1'b1;
    e.outBit = 1'b1;
    e.ht = 1'b1;
    chk("ctl defaults", e, ctl);
    chk("fail out reset", 0, pfoN);
    chk("protect reset", 1, wp);
  endtask

  // Sense is held low through the deselect, so a high output proves the forcing
  task automatic pwr_up(input int n);
    int d0;
    int s0;
    int got;
    d0 = dselCnt;
    s0 = stbCnt;
    senseReq <= 1'b1;
    mains <= 1'b1;
    waitsig(1, 1'b1, "fail out forced");
    wr(8'h0c, 32'hc0, 1'b1);
    for (int i = 0; i < 3000 && wp !== 1'b0; i++) @(posedge sys_clk);
    got = dselCnt - d0;
    chk("deselect length", n, got);
    chk("power-up test", 1, stbCnt - s0);
    waitsig(1, 1'b0, "fail out tracks");
    senseReq <= 1'b0;
    waitsig(1, 1'b1, "fail out clears");
  endtask

  task automatic pwr_down();
    int s0;
    mains <= 1'b0;
    waitsig(1, 1'b0, "backup fail low");
    s0 = stbCnt;
    for (int i = 0; i < 300; i++) begin
      senseReq <= i[2];
      @(posedge sys_clk);
    end
    chk("backup fail held", 0, pfoN);
    chk("backup protect", 1, wp);
    chk("backup no test", 0, stbCnt - s0);
  endtask

  task automatic t_regs();
    rd(8'h04, 32'h80, "halt default");
    rd(8'h10, 32'h00, "length select");
    rd(8'h24, 32'h00, "watchdog");
    rd(8'h28, 32'h00, "alarm enables");
    rd(8'h30, 32'h40, "update flag");
    rd(8'h20, 32'h81, "level bit");
    rd(8'h0c, 32'h00, "century refused");
    apb(1'b0, 8'h7c, 32'h0);
    chk("unmapped err", 1, rerr);
    chk("unmapped data", 0, rdat);
  endtask

  task automatic t_events();
    rd(8'h40, 32'h2, "fail event");
    chk("irq masked", 0, irq);
    wr(8'h48, 32'h2, 1'b0);
    waitsig(2, 1'b1, "irq raised");
    wr(8'h44, 32'h2, 1'b0);
    waitsig(2, 1'b0, "irq cleared");
    wr(8'h0c, 32'h80, 1'b0);
    pulse_cent();
    rd(8'h0c, 32'hc0, "century toggled");
    rd(8'h40, 32'h4, "century event");
    chk("irq other bit", 0, irq);
    wr(8'h44, 32'h4, 1'b0);
    wr(8'h0c, 32'h40, 1'b0);
    pulse_cent();
    rd(8'h0c, 32'h40, "century held");
    wr(8'h48, 32'h0, 1'b0);
  endtask

  task automatic t_pin();
    wr(8'h20, 32'h00, 1'b0);
    waitsig(0, 1'b1, "pin low");
    wr(8'h20, 32'h80, 1'b0);
    waitsig(0, 1'b0, "pin follows");
    ftWave <= 1'b0;
    wr(8'h20, 32'h40, 1'b0);
    waitsig(0, 1'b1, "test wave low");
    wr(8'h24, 32'h01, 1'b0);
    waitsig(0, 1'b0, "watchdog owns");
    wdFire <= 1'b1;
    waitsig(0, 1'b1, "watchdog fires");
    wdFire <= 1'b0;
    ftWave <= 1'b1;
    wr(8'h24, 32'h00, 1'b0);
    wr(8'h20, 32'h80, 1'b0);
    wr(8'h28, 32'h80, 1'b0);
    alarm <= 1'b1;
    waitsig(0, 1'b1, "alarm owns pin");
    alarm <= 1'b0;
    waitsig(0, 1'b0, "alarm released");
    wr(8'h28, 32'h00, 1'b0);
  endtask

  task automatic t_cell();
    cellReq <= 1'b1;
    wait_tests(2);
    chk("daily period", DayC, gap);
    rd(8'h3c, 32'h10, "weak set");
    rd(8'h40, 32'h1, "weak event");
    wr(8'h44, 32'h1, 1'b0);
    cellReq <= 1'b0;
    rd(8'h3c, 32'h10, "weak held");
    wait_tests(2);
    rd(8'h3c, 32'h00, "weak cleared");
  endtask

  task automatic t_retain();
    wr(8'h04, 32'h00, 1'b0);
    wr(8'h20, 32'hc0, 1'b0);
    wr(8'h24, 32'h05, 1'b0);
    wr(8'h28, 32'he0, 1'b0);
    wr(8'h30, 32'h00, 1'b0);
    pwr_down();
    pwr_up(LongC);
    rd(8'h04, 32'h00, "halt kept");
    rd(8'h20, 32'h81, "level kept");
    rd(8'h24, 32'h00, "watchdog cleared");
    rd(8'h28, 32'h00, "enables cleared");
    rd(8'h30, 32'h40, "update set");
  endtask

  task automatic t_short();
    wr(8'h10, 32'h80, 1'b0);
    rd(8'h10, 32'h80, "length select");
    pwr_down();
    pwr_up(ShortC);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    t_reset();
    rst <= 1'b0;
    pwr_up(DefC);
    t_regs();
    t_events();
    t_pin();
    t_cell();
    t_retain();
    t_short();
    finish_test();
  end
endmodule
